// File: rtl/tdp_host.sv
// Sender that frames signalling descriptors for a return-channel terminal.
`timescale 1ns/1ps
`default_nettype none
`include "tdp_params.svh"
// Contract
// - Each descriptor opens with an 8-bit tag naming its type.
// - An 8-bit length follows, counting only the bytes after it.
// - Connection-control payload kept at or below 255 bytes.
// - Mobility body: 16-bit command, MSB first, then 16-bit argument.
// - Reserved bits precede information bits on their line and are ignored.
// - Encrypted unicast messages fill reserved bits with random values.
// - Correction extension carries an 8-bit superframe identifier.
// - A 16-bit superframe count modulo 65536 follows.
// - Frame number sits in low 5 bits after 3 reserved bits.
// - Slot number sits in low 11 bits of a word after 5 reserved bits.
module tdp_host (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic [5:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	output logic irq_o,
	output logic [7:0] tx_data_o,
	output logic tx_valid_o,
	output logic tx_sof_o,
	output logic tx_eof_o,
	input wire logic tx_ready_i
);
	tdp_pkg::tdp_regs_t r;
	tdp_pkg::tdp_regs_t next_r;
	tdp_mem_if mem_bus ();
	logic [15:0] rnd;
	logic step;

	// ==========================================================================
	// Helpers.
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (nw & m);
	endfunction : merge

	function automatic logic cmd_refused(input logic [15:0] c);
		return (c == `TDP_CMD_RSV_SINGLE) || ((c >= `TDP_CMD_RSV_LO) && (c <= `TDP_CMD_RSV_HI));
	endfunction : cmd_refused

	// ==========================================================================
	// Submodules.
	tdp_payload_mem #(
		.DEPTH(256)
	) u_mem (
		.clk_i(clk_i),
		.ce_i(ce_i),
		.port(mem_bus.mem)
	);

	tdp_lfsr u_lfsr (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.ce_i(ce_i),
		.step_i(step),
		.rnd_o(rnd)
	);

	// ==========================================================================
	// Next-state logic.
	logic wr_hit;
	logic rd_hit;
	logic [3:0] widx;
	logic [31:0] cur;
	logic [31:0] wv;
	logic load;
	logic busy;
	logic [7:0] rsv;
	logic [7:0] body;
	logic [15:0] arg_out;
	logic done_ev;
	logic refuse_ev;
	logic start;

	always_comb begin
		next_r = r;
		widx = avs_address_i[5:2];
		wr_hit = avs_write_i;
		rd_hit = avs_read_i && !r.rd_ack;
		busy = (r.st != tdp_pkg::TDP_IDLE) || r.tx_valid;
		load = !r.tx_valid || tx_ready_i;
		step = 1'b0;
		done_ev = 1'b0;
		refuse_ev = 1'b0;
		start = 1'b0;
		cur = 32'h0000_0000;
		wv = 32'h0000_0000;
		// Reserved positions carry a fixed fill unless encrypted unicast asks for noise.
		rsv = r.rnd ? rnd[7:0] : `TDP_RSV_FILL;
		// The argument is reserved for every code but the absence time.
		arg_out = (r.cmd == `TDP_CMD_ABSENCE) ? r.arg : {rsv, rsv};

		// Body byte at the current index; connection payload comes from memory unaltered.
		case (r.kind)
			tdp_pkg::TDP_KIND_MOB: begin
				case (r.idx[1:0])
					2'd0: body = r.cmd[15:8];
					2'd1: body = r.cmd[7:0];
					2'd2: body = arg_out[15:8];
					default: body = arg_out[7:0];
				endcase
			end
			tdp_pkg::TDP_KIND_CORR: begin
				case (r.idx[2:0])
					3'd0: body = r.sfid;
					3'd1: body = r.sfcnt[15:8];
					3'd2: body = r.sfcnt[7:0];
					3'd3: body = {rsv[7:5], r.frame};
					3'd4: body = {rsv[7:3], r.slot[10:8]};
					default: body = r.slot[7:0];
				endcase
			end
			default: body = mem_bus.rdata;
		endcase

		// ======================================================================
		// Register writes.
		if (wr_hit) begin
			case (widx)
				`TDP_OFS_CTRL: begin
					if (avs_byteenable_i[0]) begin
						next_r.kind = tdp_pkg::tdp_kind_t'(avs_writedata_i[`TDP_CTRL_KIND_LO +: 2]);
						next_r.rnd = avs_writedata_i[`TDP_CTRL_RAND];
						start = avs_writedata_i[`TDP_CTRL_START];
					end
				end
				`TDP_OFS_TAG: begin
					wv = merge({24'h00_0000, r.tag}, avs_writedata_i, avs_byteenable_i);
					next_r.tag = wv[7:0];
				end
				`TDP_OFS_LEN: begin
					wv = merge({24'h00_0000, r.len}, avs_writedata_i, avs_byteenable_i);
					next_r.len = wv[7:0];
				end
				`TDP_OFS_CMD: begin
					wv = merge({r.cmd, r.arg}, avs_writedata_i, avs_byteenable_i);
					next_r.cmd = wv[31:16];
					next_r.arg = wv[15:0];
				end
				`TDP_OFS_CORR0: begin
					wv = merge({8'h00, r.sfcnt, r.sfid}, avs_writedata_i, avs_byteenable_i);
					next_r.sfid = wv[7:0];
					next_r.sfcnt = wv[23:8];
				end
				`TDP_OFS_CORR1: begin
					wv = merge({5'h00, r.slot, 11'h000, r.frame}, avs_writedata_i, avs_byteenable_i);
					next_r.frame = wv[4:0];
					next_r.slot = wv[26:16];
				end
				`TDP_OFS_IRQ_MSK: begin
					wv = merge({30'h0000_0000, r.irq_msk}, avs_writedata_i, avs_byteenable_i);
					next_r.irq_msk = wv[1:0];
				end
				`TDP_OFS_PAY_ADDR: begin
					wv = merge({24'h00_0000, r.pay_addr}, avs_writedata_i, avs_byteenable_i);
					next_r.pay_addr = wv[7:0];
				end
				`TDP_OFS_PAY_DATA: begin
					next_r.pay_addr = r.pay_addr + 8'h01;
				end
				default: begin
				end
			endcase
		end

		// ======================================================================
		// Register reads, answered one cycle after the request is seen.
		case (widx)
			`TDP_OFS_CTRL: cur = {28'h000_0000, r.rnd, r.kind, 1'b0};
			`TDP_OFS_TAG: cur = {24'h00_0000, r.tag};
			`TDP_OFS_LEN: cur = {24'h00_0000, r.len};
			`TDP_OFS_CMD: cur = {r.cmd, r.arg};
			`TDP_OFS_CORR0: cur = {8'h00, r.sfcnt, r.sfid};
			`TDP_OFS_CORR1: cur = {5'h00, r.slot, 11'h000, r.frame};
			`TDP_OFS_STATUS: cur = {31'h0000_0000, busy};
			`TDP_OFS_IRQ_STS: cur = {30'h0000_0000, r.irq_sts};
			`TDP_OFS_IRQ_MSK: cur = {30'h0000_0000, r.irq_msk};
			`TDP_OFS_PAY_ADDR: cur = {24'h00_0000, r.pay_addr};
			default: cur = 32'h0000_0000;
		endcase
		next_r.rd_ack = rd_hit;
		if (rd_hit) begin
			next_r.rdata = cur;
		end

		// ======================================================================
		// Descriptor sequencer.
		if (load && r.tx_valid) begin
			next_r.tx_valid = 1'b0;
		end
		case (r.st)
			tdp_pkg::TDP_IDLE: begin
				if (start) begin
					if (busy || ((r.kind == tdp_pkg::TDP_KIND_MOB) && cmd_refused(r.cmd))) begin
						refuse_ev = 1'b1;
					end else begin
						next_r.st = tdp_pkg::TDP_SEND_TAG;
						case (r.kind)
							tdp_pkg::TDP_KIND_MOB: next_r.blen = `TDP_MOB_BODY_LEN;
							tdp_pkg::TDP_KIND_CORR: next_r.blen = `TDP_CORR_BODY_LEN;
							default: next_r.blen = r.len;
						endcase
					end
				end
			end
			tdp_pkg::TDP_SEND_TAG: begin
				if (start) begin
					refuse_ev = 1'b1;
				end
				if (load) begin
					next_r.tx_data = r.tag;
					next_r.tx_valid = 1'b1;
					next_r.tx_sof = 1'b1;
					next_r.tx_eof = 1'b0;
					next_r.st = tdp_pkg::TDP_SEND_LEN;
					next_r.idx = 8'h00;
				end
			end
			tdp_pkg::TDP_SEND_LEN: begin
				if (start) begin
					refuse_ev = 1'b1;
				end
				if (load) begin
					next_r.tx_data = r.blen;
					next_r.tx_valid = 1'b1;
					next_r.tx_sof = 1'b0;
					next_r.tx_eof = (r.blen == 8'h00);
					next_r.st = (r.blen == 8'h00) ? tdp_pkg::TDP_IDLE : tdp_pkg::TDP_SEND_BODY;
					done_ev = (r.blen == 8'h00);
				end
			end
			tdp_pkg::TDP_SEND_BODY: begin
				if (start) begin
					refuse_ev = 1'b1;
				end
				if (load) begin
					step = 1'b1;
					next_r.tx_data = body;
					next_r.tx_valid = 1'b1;
					next_r.tx_sof = 1'b0;
					next_r.tx_eof = (r.idx == (r.blen - 8'h01));
					next_r.idx = r.idx + 8'h01;
					if (r.idx == (r.blen - 8'h01)) begin
						next_r.st = tdp_pkg::TDP_IDLE;
						done_ev = 1'b1;
					end
				end
			end
			default: next_r.st = tdp_pkg::TDP_IDLE;
		endcase

		// ======================================================================
		// Sticky events: a new event wins over a write-one clear in the same cycle.
		if (wr_hit && (widx == `TDP_OFS_IRQ_STS) && avs_byteenable_i[0]) begin
			next_r.irq_sts = r.irq_sts & ~avs_writedata_i[1:0];
		end
		if (done_ev) begin
			next_r.irq_sts[`TDP_IRQ_DONE] = 1'b1;
		end
		if (refuse_ev) begin
			next_r.irq_sts[`TDP_IRQ_REFUSED] = 1'b1;
		end
	end

	// ==========================================================================
	// State register.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			r <= '{st: tdp_pkg::TDP_IDLE, kind: tdp_pkg::TDP_KIND_CONN, tag: `TDP_TAG_RESET, default: '0};
		end else if (ce_i) begin
			r <= next_r;
		end
	end

	// ==========================================================================
	// Memory hookup: the read address leads by one cycle so data meet the index.
	assign mem_bus.we = wr_hit && (widx == `TDP_OFS_PAY_DATA) && avs_byteenable_i[0];
	assign mem_bus.waddr = r.pay_addr;
	assign mem_bus.wdata = avs_writedata_i[7:0];
	assign mem_bus.raddr = next_r.idx;

	// ==========================================================================
	// Outputs.
	assign avs_readdata_o = r.rdata;
	assign avs_waitrequest_o = avs_read_i && !r.rd_ack;
	assign irq_o = |(r.irq_sts & r.irq_msk);
	assign tx_data_o = r.tx_data;
	assign tx_valid_o = r.tx_valid;
	assign tx_sof_o = r.tx_sof;
	assign tx_eof_o = r.tx_eof;
endmodule : tdp_host
`default_nettype wire

// File: include/tdp_params.svh
// Constants for the terminal descriptor sender: register offsets, fields, reset values and codes.
`ifndef TDP_PARAMS_SVH
`define TDP_PARAMS_SVH

// ==========================================================================
// Register word indices, one aligned 32-bit word each.
`define TDP_OFS_CTRL 4'h0
`define TDP_OFS_TAG 4'h1
`define TDP_OFS_LEN 4'h2
`define TDP_OFS_CMD 4'h3
`define TDP_OFS_CORR0 4'h4
`define TDP_OFS_CORR1 4'h5
`define TDP_OFS_STATUS 4'h6
`define TDP_OFS_IRQ_STS 4'h7
`define TDP_OFS_IRQ_MSK 4'h8
`define TDP_OFS_PAY_ADDR 4'h9
`define TDP_OFS_PAY_DATA 4'hA

// ==========================================================================
// Control register fields.
`define TDP_CTRL_START 0
`define TDP_CTRL_KIND_LO 1
`define TDP_CTRL_RAND 3

// ==========================================================================
// Interrupt bits.
`define TDP_IRQ_DONE 0
`define TDP_IRQ_REFUSED 1

// ==========================================================================
// Descriptor layout.
`define TDP_MOB_BODY_LEN 8'h04
`define TDP_CORR_BODY_LEN 8'h06
`define TDP_MAX_PAYLOAD 8'hFF

// ==========================================================================
// Mobility command codes.
`define TDP_CMD_NONE 16'h0000
`define TDP_CMD_RSV_SINGLE 16'h0004
`define TDP_CMD_ABSENCE 16'h0007
`define TDP_CMD_RSV_LO 16'h0008
`define TDP_CMD_RSV_HI 16'h8FFF

// ==========================================================================
// Reset values and the fixed reserved-bit fill.
`define TDP_RSV_FILL 8'hFF
`define TDP_LFSR_SEED 16'hACE1
`define TDP_TAG_RESET 8'h00

`endif

// File: include/tdp_pkg.sv
// Types for the terminal descriptor sender.
package tdp_pkg;

	// ==========================================================================
	// Descriptor kinds and sequencer states.
	typedef enum logic [1:0] {
		TDP_KIND_CONN,
		TDP_KIND_MOB,
		TDP_KIND_CORR,
		TDP_KIND_RAW
	} tdp_kind_t;

	typedef enum logic [1:0] {
		TDP_IDLE,
		TDP_SEND_TAG,
		TDP_SEND_LEN,
		TDP_SEND_BODY
	} tdp_state_t;

	// ==========================================================================
	// All state of the top module.
	typedef struct packed {
		tdp_state_t st;
		tdp_kind_t kind;
		logic rnd;
		logic [7:0] tag;
		logic [7:0] len;
		logic [15:0] cmd;
		logic [15:0] arg;
		logic [7:0] sfid;
		logic [15:0] sfcnt;
		logic [4:0] frame;
		logic [10:0] slot;
		logic [7:0] idx;
		logic [7:0] blen;
		logic [7:0] pay_addr;
		logic [1:0] irq_sts;
		logic [1:0] irq_msk;
		logic rd_ack;
		logic [31:0] rdata;
		logic [7:0] tx_data;
		logic tx_valid;
		logic tx_sof;
		logic tx_eof;
	} tdp_regs_t;

endpackage : tdp_pkg

// File: include/tdp_mem_if.sv
// Interface between the sequencer and its payload memory.
`timescale 1ns/1ps
`default_nettype none
interface tdp_mem_if;
	logic we;
	logic [7:0] waddr;
	logic [7:0] wdata;
	logic [7:0] raddr;
	logic [7:0] rdata;

	modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
	modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : tdp_mem_if
`default_nettype wire

// File: rtl/tdp_payload_mem.sv
// Payload byte memory with registered read data.
`timescale 1ns/1ps
`default_nettype none
module tdp_payload_mem #(
	parameter int DEPTH = 256
) (
	input wire logic clk_i,
	input wire logic ce_i,
	tdp_mem_if.mem port
);
	logic [7:0] store [DEPTH];
	logic [7:0] rd_q;

	always_ff @(posedge clk_i) begin
		if (ce_i) begin
			if (port.we) begin
				store[port.waddr] <= port.wdata;
			end
			rd_q <= store[port.raddr];
		end
	end

	assign port.rdata = rd_q;
endmodule : tdp_payload_mem
`default_nettype wire

// File: rtl/tdp_lfsr.sv
// Pseudo-random source for reserved-bit filling, stepped once per body byte sent.
`timescale 1ns/1ps
`default_nettype none
`include "tdp_params.svh"
module tdp_lfsr (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic step_i,
	output logic [15:0] rnd_o
);
	logic [15:0] lfsr;
	logic [15:0] next_lfsr;

	always_comb begin
		next_lfsr = lfsr;
		if (step_i) begin
			next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			lfsr <= `TDP_LFSR_SEED;
		end else if (ce_i) begin
			lfsr <= next_lfsr;
		end
	end

	assign rnd_o = lfsr;
endmodule : tdp_lfsr
`default_nettype wire

// File: dv/tdp_host_asserts.sv
// Checker for the sender's bus and byte stream ports.
`timescale 1ns/1ps
`default_nettype none
module tdp_host_asserts (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic ce_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	input wire logic irq_o,
	input wire logic [7:0] tx_data_o,
	input wire logic tx_valid_o,
	input wire logic tx_sof_o,
	input wire logic tx_eof_o,
	input wire logic tx_ready_i
);
	// ==========
	// Position of the byte in its descriptor.
	logic [8:0] cnt;
	logic [7:0] lenb;
	logic take;
	assign take = ce_i && tx_valid_o && tx_ready_i;
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			cnt <= 9'h000;
		end else if (take) begin
			cnt <= tx_eof_o ? 9'h000 : cnt + 9'h001;
		end
		if (take && cnt == 9'h001) begin
			lenb <= tx_data_o;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========
	// Assertions.
	sequence s_held;
		tx_valid_o && $stable(tx_data_o) && $stable(tx_eof_o);
	endsequence
	sequence s_one_wait;
		avs_waitrequest_o ##1 !avs_waitrequest_o;
	endsequence
	a_byte_stands: assert property (ce_i && tx_valid_o && !tx_ready_i |=> s_held)
		else $error("Byte not held.");
	a_sof_first: assert property (tx_valid_o |-> tx_sof_o == (cnt == 9'h000))
		else $error("Bad start mark.");
	a_len_empty: assert property (tx_valid_o && cnt == 9'h001 |-> tx_eof_o == (tx_data_o == 8'h00))
		else $error("Bad end mark on length.");
	a_body_end: assert property (tx_valid_o && cnt > 9'h001 |-> tx_eof_o == (cnt == {1'b0, lenb} + 9'h001))
		else $error("Bad end mark in body.");
	a_end_release: assert property (take && tx_eof_o |=> !tx_valid_o)
		else $error("Valid after last byte.");
	a_reset_idle: assert property (rst_n_i && !$past(rst_n_i) |-> !tx_valid_o && !irq_o)
		else $error("Busy after reset.");
	a_write_nowait: assert property (avs_write_i |-> !avs_waitrequest_o)
		else $error("Write stalled.");
	a_read_wait: assert property ($rose(avs_read_i) |-> s_one_wait)
		else $error("Read wait wrong.");
endmodule : tdp_host_asserts
bind tdp_host tdp_host_asserts tdp_host_asserts_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(ce_i),
	.avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o), .irq_o(irq_o),
	.tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o), .tx_sof_o(tx_sof_o), .tx_eof_o(tx_eof_o),
	.tx_ready_i(tx_ready_i));
`default_nettype wire

// File: dv/tdp_sink.sv
// Terminal model that takes descriptor bytes and decodes them.
`timescale 1ns/1ps
`default_nettype none
module tdp_sink #(
	parameter logic [7:0] MOB_TAG = 8'h01,
	parameter logic [7:0] CORR_TAG = 8'h02
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic slow_i,
	input wire logic [7:0] data_i,
	input wire logic valid_i,
	input wire logic sof_i,
	input wire logic eof_i,
	output logic ready_o
);
	logic [7:0] bytes [258];
	logic [8:0] n;
	int ndesc;
	logic ph;
	logic sync_always;
	logic [15:0] cmd, absence;
	logic [1:0] ho;
	logic [10:0] slot;
	logic [1:0] rpt;
	// ==========
	// A slow terminal is ready only every other cycle, so the sender must hold each byte.
	assign ready_o = !slow_i || ph;
	always_ff @(posedge clk_i) begin
		ph <= rst_n_i && !ph;
		if (!rst_n_i) begin
			n <= 9'h000;
			ndesc <= 0;
		end else if (valid_i && ready_o) begin
			bytes[sof_i ? 9'h000 : n] <= data_i;
			n <= sof_i ? 9'h001 : n + 9'h001;
			ndesc <= ndesc + int'(eof_i);
		end
	end
	// ==========
	// An unknown tag decodes to nothing; its bytes are still stored and counted.
	assign cmd = bytes[0] == MOB_TAG ? {bytes[2], bytes[3]} : 16'h0000;
	assign ho = cmd == 16'h0001 ? 2'b11 : cmd == 16'h0002 ? 2'b01 : cmd == 16'h0003 ? 2'b10 : 2'b00;
	assign rpt = cmd == 16'h0005 ? 2'b01 : cmd == 16'h0006 ? 2'b10 : 2'b00;
	assign absence = cmd == 16'h0007 ? {bytes[4], bytes[5]} : 16'h0000;
	assign sync_always = cmd == 16'h0007 && absence == 16'h0000;
	assign slot = bytes[0] == CORR_TAG ? {bytes[6][2:0], bytes[7]} : 11'h000;
endmodule : tdp_sink
`default_nettype wire

// File: dv/tb_tdp_host.sv
// Self-checking bench for the descriptor sender.
`timescale 1ns/1ps
`default_nettype none
`include "tdp_params.svh"
module tb_tdp_host;
	localparam logic [7:0] MT = 8'h61;
	localparam logic [7:0] CT = 8'h62;
	logic clk_i = 0;
	logic rst_n_i = 0;
	logic rd = 0;
	logic wr = 0;
	logic slow = 0;
	logic rdy, wrq, irq, txv, txs, txe;
	logic [5:0] adr = 0;
	logic [31:0] wd = 0;
	logic [31:0] q, rdat;
	logic [7:0] txd;
	logic [7:0] ex [$];
	logic [3:0] zofs [4] = '{`TDP_OFS_TAG, `TDP_OFS_STATUS, `TDP_OFS_IRQ_STS, 4'hF};
	logic [15:0] codes [11] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0005, 16'h0006, 16'h0007,
		16'h9000, 16'h0004, 16'h0008, 16'h8FFF};
	int err_count = 0;
	int cmp_count = 0;
	always #25 clk_i = !clk_i;
	tdp_host tdp_host_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .avs_address_i(adr),
		.avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
		.avs_readdata_o(rdat), .avs_waitrequest_o(wrq), .irq_o(irq), .tx_data_o(txd), .tx_valid_o(txv),
		.tx_sof_o(txs), .tx_eof_o(txe), .tx_ready_i(rdy));
	tdp_sink #(.MOB_TAG(MT), .CORR_TAG(CT)) tdp_sink_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .slow_i(slow),
		.data_i(txd), .valid_i(txv), .sof_i(txs), .eof_i(txe), .ready_o(rdy));
	// ==========
	// Tasks.
	task automatic give_verdict;
		if (err_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	// Waitrequest and read data are taken at the rising edge itself, before the registers behind them move on.
	task automatic bus(input logic r, input logic [3:0] o, input logic [31:0] d);
		logic w;
		int k;
		k = 0;
		@(posedge clk_i);
		adr <= {o, 2'b00};
		wd <= d;
		rd <= r;
		wr <= !r;
		do begin
			@(posedge clk_i);
			w = wrq;
			q = rdat;
			k++;
		end while (w && k < 20);
		rd <= 0;
		wr <= 0;
		if (w) begin
			err_count++;
			give_verdict();
		end
	endtask : bus
	// The top bit of kind lands on the control register's noise-fill bit.
	task automatic send(input logic [2:0] kind, input logic [7:0] tg, input logic nb);
		int k;
		int d0;
		d0 = tdp_sink_inst.ndesc;
		bus(0, `TDP_OFS_TAG, tg);
		bus(0, `TDP_OFS_CTRL, {kind, 1'b0});
		bus(0, `TDP_OFS_CTRL, {kind, 1'b1});
		k = 0;
		while (k < 400 && tdp_sink_inst.ndesc == d0) begin
			@(negedge clk_i);
			k++;
		end
		chk("descriptors", tdp_sink_inst.ndesc, d0 + nb);
		if (nb && k == 400)
			give_verdict();
		if (nb && ex.size() > 0) begin
			chk("length", tdp_sink_inst.n, ex.size());
			foreach (ex[i]) chk("byte", tdp_sink_inst.bytes[i], ex[i]);
		end
	endtask : send
	// ==========
	// Main sequence.
	initial begin
		logic [15:0] c;
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1;
		foreach (zofs[i]) begin
			bus(1, zofs[i], 0);
			chk("reset value", q, 0);
		end
		bus(0, `TDP_OFS_IRQ_MSK, 0);
		foreach (codes[i]) begin
			c = codes[i];
			bus(0, `TDP_OFS_CMD, {c, 16'h1234});
			ex = {MT, 8'h04, c[15:8], c[7:0], c == 16'h0007 ? 8'h12 : 8'hFF, c == 16'h0007 ? 8'h34 : 8'hFF};
			send(1, MT, i < 8);
			chk("handover", tdp_sink_inst.ho, c == 1 ? 3 : c == 2 ? 1 : c == 3 ? 2 : 0);
			chk("report", tdp_sink_inst.rpt, c == 5 ? 1 : c == 6 ? 2 : 0);
			chk("absence", tdp_sink_inst.absence, c == 16'h0007 ? 16'h1234 : 16'h0000);
			chk("sync", tdp_sink_inst.sync_always, 0);
		end
		bus(0, `TDP_OFS_CMD, 32'h0007_0000);
		ex = {MT, 8'h04, 8'h00, 8'h07, 8'h00, 8'h00};
		send(1, MT, 1);
		chk("sync", tdp_sink_inst.sync_always, 1);
		chk("irq line", irq, 0);
		bus(1, `TDP_OFS_IRQ_STS, 0);
		chk("irq status", q, 3);
		bus(0, `TDP_OFS_IRQ_MSK, 2);
		@(negedge clk_i);
		chk("irq line", irq, 1);
		bus(0, `TDP_OFS_IRQ_STS, 2);
		@(negedge clk_i);
		chk("irq line", irq, 0);
		bus(0, `TDP_OFS_CORR0, 32'h00BE_EFA5);
		bus(0, `TDP_OFS_CORR1, 32'h05A3_0013);
		slow <= 1;
		ex = {CT, 8'h06, 8'hA5, 8'hBE, 8'hEF, 8'hF3, 8'hFD, 8'hA3};
		send(2, CT, 1);
		chk("slot", tdp_sink_inst.slot, 11'h5A3);
		// Noise fill makes the reserved bits unpredictable, so only the information bits are compared.
		ex = {};
		send(6, CT, 1);
		chk("length", tdp_sink_inst.n, 8);
		chk("superframe", tdp_sink_inst.bytes[2], 8'hA5);
		chk("count", {tdp_sink_inst.bytes[3], tdp_sink_inst.bytes[4]}, 16'hBEEF);
		chk("frame", tdp_sink_inst.bytes[5][4:0], 5'h13);
		chk("slot", tdp_sink_inst.slot, 11'h5A3);
		bus(0, `TDP_OFS_PAY_ADDR, 0);
		slow <= 0;
		bus(0, `TDP_OFS_PAY_DATA, 8'h3C);
		bus(0, `TDP_OFS_PAY_DATA, 8'hC3);
		bus(0, `TDP_OFS_PAY_DATA, 8'h5A);
		bus(0, `TDP_OFS_LEN, 3);
		ex = {8'h60, 8'h03, 8'h3C, 8'hC3, 8'h5A};
		send(0, 8'h60, 1);
		bus(0, `TDP_OFS_LEN, 0);
		ex = {8'h7E, 8'h00};
		send(3, 8'h7E, 1);
		give_verdict();
	end
endmodule : tb_tdp_host
`default_nettype wire
